// File: rtl/dhq_queue.sv
// diagnosis history queue: message slots, pointers, flags, access answers
// assumes requests and messages come from logic on the same clock
//
// Functional notes
// - history holds at most 100 messages
// - capacity entry reads slot count; slots from 6
// - capacity fixed; writes to it refused
// - newest pointer in 6..105, zero after reset
// - flags bit 4 selects acknowledge mode
// - overwrite mode zeroes ack pointer on overwrite
// - overwrite mode zero write clears pointers, counts, pending and overrun bit
// - ack writes of 1..5 refused, too low
// - overwrite mode stores valid ack unchecked
// - ack writes above count refused, too high
// - ack mode ack pointer reads latest acknowledged
// - ack mode zero write deletes acknowledged messages
// - ack mode valid write acknowledges up to slot
// - overwrite mode pending shows newest unread
// - ack mode pending when pointers differ
// - flags bits 1..3 block message classes
// - overwrite mode overrun sets flags bit 5
// - ack mode full queue drops, sets bit 5
// - first message at 6, successive, wraps
`timescale 1ns/10ps
`default_nettype none

module dhq_queue
  import dhq_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic [7:0]         req_subindex,
  input  wire logic [15:0]        req_wdata,
  input  wire logic               msg_valid,
  input  wire logic [1:0]         msg_class,
  input  wire logic [MSG_W-1:0]   msg_data,
  output var  logic               rsp_valid,
  output var  logic [15:0]        rsp_data,
  output var  logic               rsp_abort,
  output var  logic [31:0]        rsp_code
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] next_slot(input logic [7:0] s);
    if (s == POINTER_RESET || s >= LAST_SLOT) begin
      next_slot = FIRST_SLOT;
    end else begin
      next_slot = s + 8'h01;
    end
  endfunction : next_slot

  // messages stored after slot a up to and including slot b
  function automatic logic [7:0] slot_dist(input logic [7:0] a,
                                           input logic [7:0] b);
    if (b == POINTER_RESET) begin
      slot_dist = COUNT_RESET;
    end else if (b >= a) begin
      slot_dist = b - a;
    end else begin
      slot_dist = b + CAPACITY - a;
    end
  endfunction : slot_dist

  function automatic logic [6:0] slot_index(input logic [7:0] s);
    logic [7:0] d;
    d = s - FIRST_SLOT;
    slot_index = d[6:0];
  endfunction : slot_index

  // ==========================================================
  // state
  logic [MSG_W-1:0] mem_q [0:DEPTH-1];
  logic [7:0]       newest_q, newest_d;
  logic [7:0]       ack_q, ack_d;
  logic [7:0]       fill_q, fill_d;
  logic [7:0]       unack_q, unack_d;
  logic             unread_q, unread_d;
  logic [15:0]      flags_q, flags_d;
  logic [15:0]      rdata_d;
  logic             abort_d;
  logic [31:0]      code_d;
  logic             store;
  logic             blocked;
  logic             rd;
  logic             wr;
  logic [7:0]       wval;
  logic [15:0]      fixed_mask;

  assign rd   = req_valid && !req_write;
  assign wr   = req_valid && req_write;
  assign wval = req_wdata[7:0];
  assign fixed_mask = ~(FLAGS_WRITABLE | FLAGS_DONTCARE);

  // class 3 is undefined and treated as an error message
  always_comb begin
    case (msg_class)
      DHQ_INFO: blocked = flags_q[FLAG_INFO_OFF];
      DHQ_WARN: blocked = flags_q[FLAG_WARN_OFF];
      default:  blocked = flags_q[FLAG_ERR_OFF];
    endcase
  end

  // ==========================================================
  // next state: access first, then message, so a new event wins
  always_comb begin
    newest_d = newest_q;
    ack_d    = ack_q;
    fill_d   = fill_q;
    unack_d  = unack_q;
    unread_d = unread_q;
    flags_d  = flags_q;
    rdata_d  = 16'h0000;
    abort_d  = 1'b0;
    code_d   = ABORT_NONE;
    store    = 1'b0;
    if (rd) begin
      case (req_subindex)
        SUBIDX_COUNT_ENTRY:   rdata_d = {8'h00, SUBIDX_COUNT};
        CAPACITY_ENTRY:       rdata_d = {8'h00, CAPACITY};
        NEWEST_POINTER_ENTRY: rdata_d = {8'h00, newest_q};
        ACK_POINTER_ENTRY:    rdata_d = {8'h00, ack_q};
        PENDING_ENTRY: begin
          if (flags_q[FLAG_ACK_MODE]) begin
            rdata_d = {15'h0000, newest_q != ack_q};
          end else begin
            rdata_d = {15'h0000, unread_q};
          end
        end
        CONTROL_FLAGS_ENTRY:  rdata_d = flags_q;
        default: begin
          if (req_subindex >= FIRST_SLOT && req_subindex <= LAST_SLOT) begin
            rdata_d = mem_q[slot_index(req_subindex)];
            if (req_subindex == newest_q) begin
              unread_d = 1'b0;
            end
          end else begin
            abort_d = 1'b1;
            code_d  = ABORT_NO_ENTRY;
          end
        end
      endcase
    end
    if (wr) begin
      case (req_subindex)
        ACK_POINTER_ENTRY: begin
          if (wval == POINTER_RESET) begin
            if (flags_q[FLAG_ACK_MODE]) begin
              fill_d = unack_q;
              ack_d  = POINTER_RESET;
              if (unack_q == COUNT_RESET) begin
                newest_d = POINTER_RESET;
              end
            end else begin
              newest_d = POINTER_RESET;
              ack_d    = POINTER_RESET;
              fill_d   = COUNT_RESET;
              unack_d  = COUNT_RESET;
              unread_d = 1'b0;
              flags_d[FLAG_OVERRUN] = 1'b0;
            end
          end else if (wval < FIRST_SLOT) begin
            abort_d = 1'b1;
            code_d  = ABORT_TOO_LOW;
          end else if (wval > SUBIDX_COUNT) begin
            abort_d = 1'b1;
            code_d  = ABORT_TOO_HIGH;
          end else begin
            // no check that the slot holds a message
            ack_d   = wval;
            unack_d = slot_dist(wval, newest_q);
          end
        end
        CONTROL_FLAGS_ENTRY: begin
          if ((req_wdata & fixed_mask) != (flags_q & fixed_mask)) begin
            abort_d = 1'b1;
            code_d  = ABORT_RANGE;
          end else begin
            flags_d = (req_wdata & FLAGS_WRITABLE)
                    | (flags_q & FLAGS_DONTCARE);
          end
        end
        default: begin
          abort_d = 1'b1;
          if (req_subindex <= LAST_SLOT) begin
            code_d = ABORT_READ_ONLY;
          end else begin
            code_d = ABORT_NO_ENTRY;
          end
        end
      endcase
    end
    if (msg_valid && !blocked) begin
      if (flags_d[FLAG_ACK_MODE] && unack_d == CAPACITY) begin
        flags_d[FLAG_OVERRUN] = 1'b1;
      end else begin
        if (!flags_d[FLAG_ACK_MODE] && fill_d == CAPACITY) begin
          if (unack_d == CAPACITY) begin
            flags_d[FLAG_OVERRUN] = 1'b1;
          end
          ack_d   = POINTER_RESET;
          unack_d = CAPACITY;
        end
        newest_d = next_slot(newest_d);
        store    = 1'b1;
        unread_d = 1'b1;
        if (fill_d != CAPACITY) begin
          fill_d = fill_d + 8'h01;
        end
        if (unack_d != CAPACITY) begin
          unack_d = unack_d + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // storage; 100 slots, no reset needed on the array
  always_ff @(posedge clock) begin
    if (store) begin
      mem_q[slot_index(newest_d)] <= msg_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      newest_q <= POINTER_RESET;
      ack_q    <= POINTER_RESET;
      fill_q   <= COUNT_RESET;
      unack_q  <= COUNT_RESET;
      unread_q <= 1'b0;
    end else begin
      newest_q <= newest_d;
      ack_q    <= ack_d;
      fill_q   <= fill_d;
      unack_q  <= unack_d;
      unread_q <= unread_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // answers, one cycle after each request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_abort <= 1'b0;
      rsp_code  <= ABORT_NONE;
    end else begin
      rsp_valid <= req_valid;
      rsp_data  <= rdata_d;
      rsp_abort <= abort_d;
      rsp_code  <= code_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    msg_valid && !blocked && !req_valid;
  endsequence

  sequence s_read_pending;
    rd && req_subindex == PENDING_ENTRY && !msg_valid;
  endsequence

  sequence s_ack_write(logic [7:0] lo, logic [7:0] hi);
    wr && req_subindex == ACK_POINTER_ENTRY && wval >= lo && wval <= hi;
  endsequence

  a_capacity_read: assert property (
    rd && req_subindex == CAPACITY_ENTRY |=>
      rsp_valid && !rsp_abort && rsp_data == 16'h0064)
    else $error("capacity entry read wrong");

  a_newest_range: assert property (
    newest_q == 8'h00 || (newest_q >= 8'h06 && newest_q <= 8'h69))
    else $error("newest pointer out of range");

  a_low_ack_refused: assert property (
    s_ack_write(8'h01, 8'h05) |=>
      rsp_abort && rsp_code == 32'h06090032)
    else $error("low ack write not refused");

  a_high_ack_refused: assert property (
    s_ack_write(8'h6A, 8'hFF) |=>
      rsp_abort && rsp_code == 32'h06090031)
    else $error("high ack write not refused");

  a_ack_store_plain: assert property (
    s_ack_write(8'h06, 8'h69) and !msg_valid |=>
      ack_q == $past(wval) && !rsp_abort)
    else $error("valid ack write not stored");

  a_full_drop: assert property (
    (flags_q[4] && unack_q == 8'h64) and s_accept |=>
      $stable(newest_q) && flags_q[5])
    else $error("full ack mode did not drop");

  a_filter_blocks: assert property (
    msg_valid && blocked && !req_valid |=> $stable(newest_q))
    else $error("blocked message was stored");

  a_overwrite_zeroes: assert property (
    (!flags_q[4] && fill_q == 8'h64) and s_accept |=> ack_q == 8'h00)
    else $error("ack pointer not zeroed on overwrite");

  a_pending_unread: assert property (
    (!flags_q[4] and s_accept) ##1 s_read_pending |=> rsp_data == 16'h0001)
    else $error("pending not set after store");

  // master reads seldom follow a store at once; cover one quiet cycle too
  a_pending_after_gap: assert property (
    (!flags_q[4] and s_accept) ##1 (!req_valid && !msg_valid) ##1
      s_read_pending |=> rsp_data == 16'h0001)
    else $error("pending not held after store");

  a_clear_all: assert property (
    (!flags_q[4] && !msg_valid) and s_ack_write(8'h00, 8'h00) |=>
      newest_q == 8'h00 && ack_q == 8'h00 && !flags_q[5] && !unread_q)
    else $error("clear all incomplete");

  a_first_slot: assert property (
    (newest_q == 8'h00) and s_accept |=> newest_q == 8'h06)
    else $error("first message not at slot 6");

endmodule : dhq_queue

`default_nettype wire

// File: include/dhq_pkg.sv
// constants and types for the diagnosis history queue
// assumes one device clock; entries reached by service data transfers
`default_nettype none

package dhq_pkg;

  // ==========================================================
  // clock
  localparam int unsigned CLK_HZ        = 20_000_000;

  // ==========================================================
  // geometry
  localparam logic [7:0]  CAPACITY      = 8'h64;
  localparam logic [7:0]  FIRST_SLOT    = 8'h06;
  localparam logic [7:0]  LAST_SLOT     = 8'h69;
  localparam logic [7:0]  SUBIDX_COUNT  = 8'h69;
  localparam int unsigned DEPTH         = 100;
  localparam int unsigned MSG_W         = 16;

  // ==========================================================
  // entry sub-indices
  localparam logic [7:0]  SUBIDX_COUNT_ENTRY   = 8'h00;
  localparam logic [7:0]  CAPACITY_ENTRY       = 8'h01;
  localparam logic [7:0]  NEWEST_POINTER_ENTRY = 8'h02;
  localparam logic [7:0]  ACK_POINTER_ENTRY    = 8'h03;
  localparam logic [7:0]  PENDING_ENTRY        = 8'h04;
  localparam logic [7:0]  CONTROL_FLAGS_ENTRY  = 8'h05;

  // ==========================================================
  // control flags word layout
  localparam int unsigned FLAG_EMCY      = 0;
  localparam int unsigned FLAG_INFO_OFF  = 1;
  localparam int unsigned FLAG_WARN_OFF  = 2;
  localparam int unsigned FLAG_ERR_OFF   = 3;
  localparam int unsigned FLAG_ACK_MODE  = 4;
  localparam int unsigned FLAG_OVERRUN   = 5;
  localparam logic [15:0] FLAGS_WRITABLE = 16'h001E;
  localparam logic [15:0] FLAGS_DONTCARE = 16'h0020;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;

  // ==========================================================
  // reset values
  localparam logic [7:0]  POINTER_RESET  = 8'h00;
  localparam logic [7:0]  COUNT_RESET    = 8'h00;

  // ==========================================================
  // abort codes
  localparam logic [31:0] ABORT_NONE      = 32'h00000000;
  localparam logic [31:0] ABORT_RANGE     = 32'h06090030;
  localparam logic [31:0] ABORT_TOO_HIGH  = 32'h06090031;
  localparam logic [31:0] ABORT_TOO_LOW   = 32'h06090032;
  // plain default; no figure given for these two
  localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
  localparam logic [31:0] ABORT_NO_ENTRY  = 32'h06090011;

  typedef enum logic [1:0] {
    DHQ_INFO  = 2'h0,
    DHQ_WARN  = 2'h1,
    DHQ_ERROR = 2'h2
  } dhq_class_t;

endpackage : dhq_pkg

`default_nettype wire

// File: test/dhq_master_model.sv
// network master model: one service data access at a time
// assumes the bench clock; drives just after the falling edge
`timescale 1ns/10ps
`default_nettype none

module dhq_master_model (
  output var  logic        req_valid,
  output var  logic        req_write,
  output var  logic [7:0]  req_subindex,
  output var  logic [15:0] req_wdata,
  input  wire logic        clock,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_abort,
  input  wire logic [31:0] rsp_code
);
  initial begin
    req_valid    = 1'b0;
    req_write    = 1'b0;
    req_subindex = 8'h00;
    req_wdata    = 16'h0000;
  end

  // ==========================================================
  // access: one-cycle request, answer sampled one cycle later
  task automatic access(input logic wr, input logic [7:0] sub,
      input logic [15:0] wd, output logic [49:0] rsp);
    @(negedge clock);
    req_valid    = 1'b1;
    req_write    = wr;
    req_subindex = sub;
    req_wdata    = wd;
    @(negedge clock);
    req_valid    = 1'b0;
    // released subindex and data lines flip so a stale value never passes
    req_subindex = ~sub;
    req_wdata    = ~wd;
    rsp = {rsp_valid, rsp_abort, rsp_code, rsp_data};
  endtask : access
endmodule : dhq_master_model

`default_nettype wire

// File: test/tb_dhq_queue.sv
// testbench for the diagnosis history queue
// assumes the master model in the same test folder
`timescale 1ns/10ps
`default_nettype none

module tb_dhq_queue;
  import dhq_pkg::*;
  logic             clock;
  logic             rst_n;
  logic             msg_valid;
  logic [1:0]       msg_class;
  logic [MSG_W-1:0] msg_data;
  logic             req_valid;
  logic             req_write;
  logic [7:0]       req_subindex;
  logic [15:0]      req_wdata;
  logic             rsp_valid;
  logic [15:0]      rsp_data;
  logic             rsp_abort;
  logic [31:0]      rsp_code;
  int               fail_count;
  int               n_checks;

  dhq_queue DUT (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_subindex(req_subindex),
    .req_wdata(req_wdata), .msg_valid(msg_valid), .msg_class(msg_class),
    .msg_data(msg_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_abort(rsp_abort), .rsp_code(rsp_code));

  dhq_master_model u_master (.clock(clock), .req_valid(req_valid),
    .req_write(req_write), .req_subindex(req_subindex),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_abort(rsp_abort), .rsp_code(rsp_code));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // answer = valid, abort, code, data; writes and aborts return 0 data
  task automatic acc(input logic wr, input logic [7:0] sub,
      input logic [15:0] wd, input logic [15:0] ed, input logic [31:0] ec);
    logic [49:0] got;
    logic [49:0] exp;
    u_master.access(wr, sub, wd, got);
    exp = {1'b1, ec != ABORT_NONE, ec, ed};
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] entry %0d expected %h seen %h", sub, exp, got);
      fail_count++;
    end
  endtask : acc

  task automatic rd(input logic [7:0] sub, input logic [15:0] ed);
    acc(1'b0, sub, 16'h0000, ed, ABORT_NONE);
  endtask : rd

  task automatic wr(input logic [7:0] sub, input logic [15:0] wd,
      input logic [31:0] ec);
    acc(1'b1, sub, wd, 16'h0000, ec);
  endtask : wr

  // n back-to-back messages, payload changes every cycle
  task automatic send(input int n, input logic [1:0] c);
    @(negedge clock);
    msg_valid = 1'b1;
    msg_class = c;
    repeat (n) begin
      msg_data = msg_data + 16'h0001;
      @(negedge clock);
    end
    msg_valid = 1'b0;
  endtask : send

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(8'h00, 16'h0069);
    rd(8'h01, 16'h0064);
    rd(8'h02, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h05, 16'h0000);
    wr(8'h01, 16'h0005, ABORT_READ_ONLY);
  endtask : t_reset

  task automatic t_first();
    send(1, DHQ_INFO);
    rd(8'h02, 16'h0006);
    rd(8'h04, 16'h0001);
    rd(8'h06, msg_data);
    rd(8'h04, 16'h0000);
  endtask : t_first

  task automatic t_ack_range();
    for (int v = 1; v <= 5; v++) begin
      wr(8'h03, 16'(v), ABORT_TOO_LOW);
    end
    wr(8'h03, 16'h006A, ABORT_TOO_HIGH);
    wr(8'h03, 16'h00FF, ABORT_TOO_HIGH);
    wr(8'h03, 16'h0009, ABORT_NONE);
    rd(8'h03, 16'h0009);
    wr(8'h03, 16'h0000, ABORT_NONE);
    rd(8'h02, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0000);
  endtask : t_ack_range

  task automatic t_block();
    wr(8'h05, 16'h0001, ABORT_RANGE);
    for (int i = 1; i <= 3; i++) begin
      wr(8'h05, 16'h0001 << i, ABORT_NONE);
      send(1, 2'(i - 1));
      rd(8'h02, 16'h0000);
    end
    wr(8'h05, 16'h0000, ABORT_NONE);
  endtask : t_block

  task automatic t_wrap();
    send(100, DHQ_WARN);
    rd(8'h02, 16'h0069);
    wr(8'h03, 16'h0032, ABORT_NONE);
    send(1, DHQ_ERROR);
    rd(8'h02, 16'h0006);
    rd(8'h03, 16'h0000);
    // oldest was acknowledged, so no overrun yet
    rd(8'h05, 16'h0000);
    wr(8'h03, 16'h0000, ABORT_NONE);
    send(101, DHQ_WARN);
    rd(8'h05, 16'h0020);
    wr(8'h03, 16'h0000, ABORT_NONE);
    rd(8'h05, 16'h0000);
  endtask : t_wrap

  task automatic t_ack_mode();
    wr(8'h05, 16'h0010, ABORT_NONE);
    rd(8'h05, 16'h0010);
    send(2, DHQ_INFO);
    rd(8'h02, 16'h0007);
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0001);
    wr(8'h03, 16'h0007, ABORT_NONE);
    rd(8'h03, 16'h0007);
    rd(8'h04, 16'h0000);
    send(100, DHQ_INFO);
    rd(8'h02, 16'h0007);
    rd(8'h05, 16'h0010);
    send(1, DHQ_INFO);
    rd(8'h02, 16'h0007);
    rd(8'h05, 16'h0030);
    wr(8'h03, 16'h0000, ABORT_NONE);
    rd(8'h03, 16'h0000);
  endtask : t_ack_mode

  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_n      = 1'b0;
    msg_valid  = 1'b0;
    msg_class  = DHQ_INFO;
    msg_data   = '0;
    fail_count = 0;
    n_checks   = 0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_first();
    t_ack_range();
    t_block();
    t_wrap();
    t_ack_mode();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_dhq_queue

`default_nettype wire
